// ---- src/uart_regs_pkg.sv ----
// constants, field layout and carrier types for the uart register block
package uart_regs_pkg;

    // ------------------------------------------------------------------
    // register offsets and selection
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_DIVISOR_HIGH = 4'h1;
    localparam logic [3:0] OFS_IDENT_FIFO   = 4'h2;
    localparam int         LCR_DIV_BIT      = 7;
    localparam logic [7:0] LCR_ENH_KEY      = 8'hbf;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] DIVISOR_HIGH_RST = 8'h00;
    localparam logic [7:0] IDENT_RST        = 8'h01;
    localparam logic [7:0] FIFO_CONTROL_RST = 8'h00;
    localparam logic [7:0] READ_ZERO        = 8'h00;

    // ------------------------------------------------------------------
    // fifo control field positions
    // ------------------------------------------------------------------
    localparam int FCR_RX_TRIG_HI = 7;
    localparam int FCR_RX_TRIG_LO = 6;
    localparam int FCR_TX_TRIG_HI = 5;
    localparam int FCR_TX_TRIG_LO = 4;
    localparam int FCR_TX_CLR_BIT = 2;
    localparam int FCR_RX_CLR_BIT = 1;
    localparam int FCR_EN_BIT     = 0;

    // ------------------------------------------------------------------
    // trigger levels, in characters or free spaces, and the fifo depth
    // ------------------------------------------------------------------
    localparam logic [6:0] LVL_1  = 7'h01;
    localparam logic [6:0] LVL_8  = 7'h08;
    localparam logic [6:0] LVL_16 = 7'h10;
    localparam logic [6:0] LVL_32 = 7'h20;
    localparam logic [6:0] LVL_56 = 7'h38;
    localparam logic [6:0] LVL_60 = 7'h3c;
    localparam logic [6:0] FIFO_DEPTH = 7'h40;

    // ------------------------------------------------------------------
    // identification codes for bits 5:0
    // ------------------------------------------------------------------
    localparam logic [5:0] ID_NONE      = 6'h01;
    localparam logic [5:0] ID_LINE_ERR  = 6'h06;
    localparam logic [5:0] ID_RX_TMO    = 6'h0c;
    localparam logic [5:0] ID_RX_DATA   = 6'h04;
    localparam logic [5:0] ID_TX_READY  = 6'h02;
    localparam logic [5:0] ID_MODEM     = 6'h00;
    localparam logic [5:0] ID_PIN_CHG   = 6'h30;
    localparam logic [5:0] ID_FLOW_CHAR = 6'h10;
    localparam logic [5:0] ID_CTS_RTS   = 6'h20;

    // interrupt sources, already gated by their enables upstream
    typedef struct packed {
        logic line_status_err;  // level
        logic rx_timeout;       // level
        logic rx_data_ready;    // level
        logic tx_ready;         // level
        logic modem;            // level
        logic pin_change;       // level
        logic xoff_seen;        // pulse
        logic xon_seen;         // pulse
        logic special_seen;     // pulse
        logic cts_rts_drop;     // level
    } irq_src_t;

endpackage

// ---- src/uart_int_ident_fifo_ctrl.sv ----
// divisor high byte, interrupt identification and fifo control registers
`timescale 1ns/1ps
`default_nettype none

module uart_int_ident_fifo_ctrl #(
    parameter int ADDR_W = 4
) (
    input  wire logic                    ref_clk,           // 125 mhz
    input  wire logic                    rst_n,             // power-on reset
    input  wire logic                    sw_reset,          // soft reset
    input  wire logic [ADDR_W-1:0]       reg_addr,          // register offset
    input  wire logic                    reg_wr,            // write strobe
    input  wire logic                    reg_rd,            // read strobe
    input  wire logic [7:0]              reg_wdata,         // write data
    input  wire logic [7:0]              line_control,      // lcr contents
    input  wire logic                    enh_enable,        // efr bit 4
    input  wire uart_regs_pkg::irq_src_t irq_src,           // sources
    output logic      [7:0]              reg_rdata,         // read data
    output logic                         reg_rvalid,        // read done
    output logic      [7:0]              divisor_high_byte, // divisor msb
    output logic                         fifo_enable,       // fifo mode
    output logic      [6:0]              rx_trigger_level,  // characters
    output logic      [6:0]              tx_trigger_level,  // spaces
    output logic      [6:0]              fifo_depth,        // 1 or 64
    output logic                         tx_fifo_clear,     // one pulse
    output logic                         rx_fifo_clear,     // one pulse
    output logic                         irq_pending        // any source but xon_seen
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    generate
        if (ADDR_W < 2) begin : g_bad_addr
            $error("ADDR_W must be at least 2");
        end
    endgenerate

    // ------------------------------------------------------------------
    // trigger decode
    // ------------------------------------------------------------------
    function automatic logic [6:0] rx_level(input logic [1:0] code);
        logic [6:0] lvl;
        lvl = uart_regs_pkg::LVL_8;
        case (code)
            2'h0: lvl = uart_regs_pkg::LVL_8;
            2'h1: lvl = uart_regs_pkg::LVL_16;
            2'h2: lvl = uart_regs_pkg::LVL_56;
            default: lvl = uart_regs_pkg::LVL_60;
        endcase
        return lvl;
    endfunction

    function automatic logic [6:0] tx_level(input logic [1:0] code);
        logic [6:0] lvl;
        lvl = uart_regs_pkg::LVL_8;
        case (code)
            2'h0: lvl = uart_regs_pkg::LVL_8;
            2'h1: lvl = uart_regs_pkg::LVL_16;
            2'h2: lvl = uart_regs_pkg::LVL_32;
            default: lvl = uart_regs_pkg::LVL_56;
        endcase
        return lvl;
    endfunction

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    logic divisor_sel;
    logic ident_sel;
    logic wr_divisor;
    logic wr_fifo_ctl;
    logic rd_ident;
    logic rd_divisor;

    always_comb begin
        divisor_sel = 1'b0;
        ident_sel   = 1'b0;
        if (line_control[uart_regs_pkg::LCR_DIV_BIT] &&
            line_control != uart_regs_pkg::LCR_ENH_KEY &&
            reg_addr == ADDR_W'(uart_regs_pkg::OFS_DIVISOR_HIGH)) begin
            divisor_sel = 1'b1;
        end else if (!line_control[uart_regs_pkg::LCR_DIV_BIT] &&
            reg_addr == ADDR_W'(uart_regs_pkg::OFS_IDENT_FIFO)) begin
            ident_sel = 1'b1;
        end
        wr_divisor  = reg_wr && divisor_sel;
        wr_fifo_ctl = reg_wr && ident_sel;
        rd_divisor  = reg_rd && divisor_sel;
        rd_ident    = reg_rd && ident_sel;
    end

    // ------------------------------------------------------------------
    // divisor high byte, survives soft reset
    // ------------------------------------------------------------------
    logic [7:0] next_divisor_high_byte;

    always_comb begin
        next_divisor_high_byte = divisor_high_byte;
        if (wr_divisor) begin
            next_divisor_high_byte = reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            divisor_high_byte <= uart_regs_pkg::DIVISOR_HIGH_RST;
        end else begin
            divisor_high_byte <= next_divisor_high_byte;
        end
    end

    // ------------------------------------------------------------------
    // fifo control
    // ------------------------------------------------------------------
    logic [1:0] rx_trig_code;
    logic [1:0] tx_trig_code;
    logic [1:0] next_rx_trig_code;
    logic [1:0] next_tx_trig_code;
    logic       next_fifo_enable;
    logic       next_tx_fifo_clear;
    logic       next_rx_fifo_clear;
    logic [6:0] next_rx_trigger_level;
    logic [6:0] next_tx_trigger_level;
    logic [6:0] next_fifo_depth;

    always_comb begin
        next_rx_trig_code  = rx_trig_code;
        next_tx_trig_code  = tx_trig_code;
        next_fifo_enable   = fifo_enable;
        next_tx_fifo_clear = 1'b0;
        next_rx_fifo_clear = 1'b0;
        if (sw_reset) begin
            next_rx_trig_code = uart_regs_pkg::FIFO_CONTROL_RST[
                uart_regs_pkg::FCR_RX_TRIG_HI:uart_regs_pkg::FCR_RX_TRIG_LO];
            next_tx_trig_code = uart_regs_pkg::FIFO_CONTROL_RST[
                uart_regs_pkg::FCR_TX_TRIG_HI:uart_regs_pkg::FCR_TX_TRIG_LO];
            next_fifo_enable  = uart_regs_pkg::FIFO_CONTROL_RST[
                uart_regs_pkg::FCR_EN_BIT];
        end else if (wr_fifo_ctl) begin
            next_fifo_enable = reg_wdata[uart_regs_pkg::FCR_EN_BIT];
            // with the fifo off the other bits are frozen
            if (reg_wdata[uart_regs_pkg::FCR_EN_BIT]) begin
                next_rx_trig_code = reg_wdata[uart_regs_pkg::FCR_RX_TRIG_HI:
                    uart_regs_pkg::FCR_RX_TRIG_LO];
                if (enh_enable) begin
                    next_tx_trig_code = reg_wdata[
                        uart_regs_pkg::FCR_TX_TRIG_HI:
                        uart_regs_pkg::FCR_TX_TRIG_LO];
                end
                next_tx_fifo_clear =
                    reg_wdata[uart_regs_pkg::FCR_TX_CLR_BIT];
                next_rx_fifo_clear =
                    reg_wdata[uart_regs_pkg::FCR_RX_CLR_BIT];
            end
        end
        // outputs follow the values being stored this cycle
        if (next_fifo_enable) begin
            next_rx_trigger_level = rx_level(next_rx_trig_code);
            next_tx_trigger_level = tx_level(next_tx_trig_code);
            next_fifo_depth       = uart_regs_pkg::FIFO_DEPTH;
        end else begin
            next_rx_trigger_level = uart_regs_pkg::LVL_1;
            next_tx_trigger_level = uart_regs_pkg::LVL_1;
            next_fifo_depth       = uart_regs_pkg::LVL_1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_trig_code     <= uart_regs_pkg::FIFO_CONTROL_RST[
                uart_regs_pkg::FCR_RX_TRIG_HI:uart_regs_pkg::FCR_RX_TRIG_LO];
            tx_trig_code     <= uart_regs_pkg::FIFO_CONTROL_RST[
                uart_regs_pkg::FCR_TX_TRIG_HI:uart_regs_pkg::FCR_TX_TRIG_LO];
            fifo_enable      <= uart_regs_pkg::FIFO_CONTROL_RST[
                uart_regs_pkg::FCR_EN_BIT];
            tx_fifo_clear    <= 1'b0;
            rx_fifo_clear    <= 1'b0;
            rx_trigger_level <= uart_regs_pkg::LVL_1;
            tx_trigger_level <= uart_regs_pkg::LVL_1;
            fifo_depth       <= uart_regs_pkg::LVL_1;
        end else begin
            rx_trig_code     <= next_rx_trig_code;
            tx_trig_code     <= next_tx_trig_code;
            fifo_enable      <= next_fifo_enable;
            tx_fifo_clear    <= next_tx_fifo_clear;
            rx_fifo_clear    <= next_rx_fifo_clear;
            rx_trigger_level <= next_rx_trigger_level;
            tx_trigger_level <= next_tx_trigger_level;
            fifo_depth       <= next_fifo_depth;
        end
    end

    // ------------------------------------------------------------------
    // flow character flags behind ident bit 4
    // ------------------------------------------------------------------
    logic pause_flag;
    logic special_flag;
    logic next_pause_flag;
    logic next_special_flag;

    always_comb begin
        next_pause_flag   = pause_flag;
        next_special_flag = special_flag;
        if (sw_reset) begin
            next_pause_flag   = 1'b0;
            next_special_flag = 1'b0;
        end else begin
            // a new detection in the clearing cycle wins
            if (irq_src.xon_seen) begin
                next_pause_flag = 1'b0;
            end
            if (irq_src.xoff_seen) begin
                next_pause_flag = 1'b1;
            end
            if (rd_ident) begin
                next_special_flag = 1'b0;
            end
            if (irq_src.special_seen) begin
                next_special_flag = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pause_flag   <= 1'b0;
            special_flag <= 1'b0;
        end else begin
            pause_flag   <= next_pause_flag;
            special_flag <= next_special_flag;
        end
    end

    // ------------------------------------------------------------------
    // priority encoder and read path
    // ------------------------------------------------------------------
    logic [5:0] ident_code;
    logic [7:0] ident_value;
    logic [7:0] next_reg_rdata;
    logic       next_reg_rvalid;
    logic       next_irq_pending;

    always_comb begin
        if (irq_src.line_status_err) begin
            ident_code = uart_regs_pkg::ID_LINE_ERR;
        end else if (irq_src.rx_timeout) begin
            ident_code = uart_regs_pkg::ID_RX_TMO;
        end else if (irq_src.rx_data_ready) begin
            ident_code = uart_regs_pkg::ID_RX_DATA;
        end else if (irq_src.tx_ready) begin
            ident_code = uart_regs_pkg::ID_TX_READY;
        end else if (irq_src.modem) begin
            ident_code = uart_regs_pkg::ID_MODEM;
        end else if (irq_src.pin_change) begin
            ident_code = uart_regs_pkg::ID_PIN_CHG;
        end else if (pause_flag || special_flag) begin
            ident_code = uart_regs_pkg::ID_FLOW_CHAR;
        end else if (irq_src.cts_rts_drop) begin
            ident_code = uart_regs_pkg::ID_CTS_RTS;
        end else begin
            ident_code = uart_regs_pkg::ID_NONE;
        end
        ident_value = {fifo_enable, fifo_enable, ident_code};
        next_irq_pending = (ident_code != uart_regs_pkg::ID_NONE);
        next_reg_rvalid  = reg_rd;
        if (rd_ident) begin
            next_reg_rdata = ident_value;
        end else if (rd_divisor) begin
            next_reg_rdata = divisor_high_byte;
        end else if (reg_rd) begin
            next_reg_rdata = uart_regs_pkg::READ_ZERO;
        end else begin
            next_reg_rdata = reg_rdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata   <= uart_regs_pkg::READ_ZERO;
            reg_rvalid  <= 1'b0;
            irq_pending <= 1'b0;
        end else begin
            reg_rdata   <= next_reg_rdata;
            reg_rvalid  <= next_reg_rvalid;
            irq_pending <= next_irq_pending;
        end
    end

endmodule

`default_nettype wire

// ---- dv/uart_int_ident_fifo_ctrl_sva.sv ----
// assertions on the ident and fifo control register block
`timescale 1ns/1ps
`default_nettype none

module uart_int_ident_fifo_ctrl_sva #(
    parameter int ADDR_W = 4
) (
    input wire logic                    ref_clk,           // clock
    input wire logic                    rst_n,             // por
    input wire logic                    sw_reset,          // soft reset
    input wire logic [ADDR_W-1:0]       reg_addr,          // offset
    input wire logic                    reg_wr,            // write
    input wire logic                    reg_rd,            // read
    input wire logic [7:0]              reg_wdata,         // wdata
    input wire logic [7:0]              line_control,      // lcr
    input wire logic                    enh_enable,        // enhance
    input wire uart_regs_pkg::irq_src_t irq_src,           // sources
    input wire logic [7:0]              reg_rdata,         // rdata
    input wire logic                    reg_rvalid,        // read done
    input wire logic [7:0]              divisor_high_byte, // divisor
    input wire logic                    fifo_enable,       // fifo mode
    input wire logic [6:0]              rx_trigger_level,  // rx level
    input wire logic [6:0]              tx_trigger_level,  // tx level
    input wire logic [6:0]              fifo_depth,        // depth
    input wire logic                    tx_fifo_clear,     // tx clear
    input wire logic                    rx_fifo_clear,     // rx clear
    input wire logic                    irq_pending        // pending
);
    wire logic div_sel = line_control[7] && line_control != 8'hbf
                         && reg_addr == ADDR_W'(1);
    wire logic id_sel  = !line_control[7] && reg_addr == ADDR_W'(2);
    wire logic fcr_wr  = reg_wr && id_sel && reg_wdata[0] && !sw_reset;

    function automatic logic [6:0] rx_lvl(input logic [1:0] c);
        return c[1] ? (c[0] ? 7'h3c : 7'h38) : (c[0] ? 7'h10 : 7'h08);
    endfunction

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // a clear written back to back legally renews the pulse
    sequence s_tx_pulse;
        tx_fifo_clear ##1 (!tx_fifo_clear || $past(fcr_wr && reg_wdata[2]));
    endsequence
    sequence s_rx_pulse;
        rx_fifo_clear ##1 (!rx_fifo_clear || $past(fcr_wr && reg_wdata[1]));
    endsequence

    a_read_answered: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_div_write: assert property (reg_wr && div_sel |=>
        divisor_high_byte == $past(reg_wdata))
        else $error("divisor write lost");
    a_div_kept: assert property (!(reg_wr && div_sel) |=>
        $stable(divisor_high_byte))
        else $error("divisor changed");
    a_ident_mirror: assert property (reg_rd && id_sel |=>
        reg_rdata[7:6] == {2{$past(fifo_enable)}})
        else $error("ident mode bits wrong");
    a_top_priority: assert property (reg_rd && id_sel &&
        irq_src.line_status_err |=> reg_rdata[5:0] == 6'h06)
        else $error("line error code wrong");
    a_rx_trigger: assert property (fcr_wr |=>
        rx_trigger_level == rx_lvl($past(reg_wdata[7:6])))
        else $error("rx trigger wrong");
    a_tx_locked: assert property (fcr_wr && !enh_enable &&
        fifo_enable |=> $stable(tx_trigger_level))
        else $error("tx trigger changed");
    a_tx_clear: assert property (fcr_wr && reg_wdata[2] |=>
        s_tx_pulse)
        else $error("tx clear pulse wrong");
    a_rx_clear: assert property (fcr_wr && reg_wdata[1] |=>
        s_rx_pulse)
        else $error("rx clear pulse wrong");
    a_depth_mode: assert property (
        fifo_depth == (fifo_enable ? 7'h40 : 7'h01))
        else $error("fifo depth wrong");
    a_pending_set: assert property (irq_src.line_status_err |=>
        irq_pending)
        else $error("pending not raised");
endmodule

bind uart_int_ident_fifo_ctrl uart_int_ident_fifo_ctrl_sva #(
    .ADDR_W(ADDR_W)
) u_uart_int_ident_fifo_ctrl_sva (
    .ref_clk(ref_clk), .rst_n(rst_n), .sw_reset(sw_reset),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .line_control(line_control),
    .enh_enable(enh_enable), .irq_src(irq_src), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .divisor_high_byte(divisor_high_byte),
    .fifo_enable(fifo_enable), .rx_trigger_level(rx_trigger_level),
    .tx_trigger_level(tx_trigger_level), .fifo_depth(fifo_depth),
    .tx_fifo_clear(tx_fifo_clear), .rx_fifo_clear(rx_fifo_clear),
    .irq_pending(irq_pending));
`default_nettype wire

// ---- dv/uart_host_model.sv ----
// host side register bus driver
`timescale 1ns/1ps
`default_nettype none

module uart_host_model (
    input  wire logic       ref_clk,     // clock
    input  wire logic       reg_rvalid,  // read done
    input  wire logic [7:0] reg_rdata,   // read data
    output var  logic [3:0] reg_addr,    // offset
    output var  logic       reg_wr,      // write strobe
    output var  logic       reg_rd,      // read strobe
    output var  logic [7:0] reg_wdata,   // write data
    output var  logic [7:0] line_control // lcr image
);
    initial begin
        reg_addr = 4'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        line_control = 8'h00;
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d, lc);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        line_control = lc;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        // idle data shows the inverse so a stale value never matches
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] lc,
                      output logic [7:0] d, output logic v);
        @(negedge ref_clk);
        reg_addr = a;
        line_control = lc;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        v = reg_rvalid;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ---- dv/test_uart_int_ident_fifo_ctrl.sv ----
// self-checking bench for the ident and fifo control block
`timescale 1ns/1ps
`default_nettype none

module test_uart_int_ident_fifo_ctrl;
    logic                    ref_clk, rst_n, sw_reset, enh_enable;
    logic                    reg_wr, reg_rd, reg_rvalid, fifo_enable;
    logic                    tx_fifo_clear, rx_fifo_clear, irq_pending;
    logic [3:0]              reg_addr;
    logic [7:0]              reg_wdata, line_control, reg_rdata;
    logic [7:0]              divisor_high_byte;
    logic [6:0]              rx_trigger_level, tx_trigger_level;
    logic [6:0]              fifo_depth;
    uart_regs_pkg::irq_src_t irq_src;
    int                      num_errors = 0;
    int                      check_count = 0;

    uart_host_model u_uart_host_model (.ref_clk(ref_clk),
        .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .line_control(line_control));

    uart_int_ident_fifo_ctrl u_uart_int_ident_fifo_ctrl (.ref_clk(ref_clk),
        .rst_n(rst_n), .sw_reset(sw_reset), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .line_control(line_control), .enh_enable(enh_enable),
        .irq_src(irq_src), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .divisor_high_byte(divisor_high_byte), .fifo_enable(fifo_enable),
        .rx_trigger_level(rx_trigger_level), .fifo_depth(fifo_depth),
        .tx_trigger_level(tx_trigger_level), .irq_pending(irq_pending),
        .tx_fifo_clear(tx_fifo_clear), .rx_fifo_clear(rx_fifo_clear));

    task automatic chk(input string n, input logic [7:0] e, g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [7:0] lc, e,
                         input string n);
        logic [7:0] d;
        logic       v;
        u_uart_host_model.rd(a, lc, d, v);
        chk("rvalid", 8'h01, 8'(v));
        chk(n, e, d);
    endtask

    task automatic t_reset();
        chk("div", 8'h00, divisor_high_byte);
        chk("depth", 8'h01, 8'(fifo_depth));
        chk("rxtrig", 8'h01, 8'(rx_trigger_level));
        rdchk(4'h2, 8'h00, 8'h01, "ident");
        rdchk(4'h1, 8'h80, 8'h00, "divrd");
    endtask

    task automatic t_divisor();
        u_uart_host_model.wr(4'h1, 8'ha5, 8'h80);
        chk("div", 8'ha5, divisor_high_byte);
        u_uart_host_model.wr(4'h1, 8'h3c, 8'hbf);
        u_uart_host_model.wr(4'h1, 8'h3c, 8'h00);
        chk("div", 8'ha5, divisor_high_byte);
        rdchk(4'h1, 8'h83, 8'ha5, "divrd");
        rdchk(4'h2, 8'h80, 8'h00, "noid");
        rdchk(4'h7, 8'h00, 8'h00, "unmapped");
        sw_reset = 1'b1;
        @(negedge ref_clk);
        sw_reset = 1'b0;
        chk("div", 8'ha5, divisor_high_byte);
        // a second power-on reset must clear what the soft one kept
        rst_n = 1'b0;
        @(negedge ref_clk);
        rst_n = 1'b1;
        chk("div", 8'h00, divisor_high_byte);
    endtask

    task automatic t_fifo();
        logic [6:0] rxl [4];
        logic [6:0] txl [4];
        rxl = '{7'h08, 7'h10, 7'h38, 7'h3c};
        txl = '{7'h08, 7'h10, 7'h20, 7'h38};
        enh_enable = 1'b1;
        for (int i = 0; i < 4; i++) begin
            u_uart_host_model.wr(4'h2, {2'(i), 2'(3 - i), 4'h7}, 8'h00);
            chk("rxtrig", 8'(rxl[i]), 8'(rx_trigger_level));
            chk("txtrig", 8'(txl[3 - i]), 8'(tx_trigger_level));
            chk("depth", 8'h40, 8'(fifo_depth));
            chk("fen", 8'h01, 8'(fifo_enable));
            chk("txclr", 8'h01, 8'(tx_fifo_clear));
            chk("rxclr", 8'h01, 8'(rx_fifo_clear));
            @(negedge ref_clk);
            chk("txclr", 8'h00, 8'(tx_fifo_clear));
            chk("rxclr", 8'h00, 8'(rx_fifo_clear));
        end
        rdchk(4'h2, 8'h00, 8'hc1, "ident");
        // soft reset drops fifo mode
        sw_reset = 1'b1;
        @(negedge ref_clk);
        sw_reset = 1'b0;
        chk("depth", 8'h01, 8'(fifo_depth));
        chk("fen", 8'h00, 8'(fifo_enable));
        enh_enable = 1'b0;
        u_uart_host_model.wr(4'h2, 8'h31, 8'h00);
        chk("txtrig", 8'h08, 8'(tx_trigger_level));
        chk("rxtrig", 8'h08, 8'(rx_trigger_level));
        u_uart_host_model.wr(4'h2, 8'hc6, 8'h00);
        chk("depth", 8'h01, 8'(fifo_depth));
        chk("fen", 8'h00, 8'(fifo_enable));
        chk("rxtrig", 8'h01, 8'(rx_trigger_level));
        chk("clr", 8'h00, {6'h0, tx_fifo_clear, rx_fifo_clear});
        rdchk(4'h2, 8'h00, 8'h01, "ident");
    endtask

    task automatic t_prio();
        int         pos [7];
        logic [5:0] code [7];
        pos = '{9, 8, 7, 6, 5, 4, 0};
        code = '{6'h06, 6'h0c, 6'h04, 6'h02, 6'h00, 6'h30, 6'h20};
        // each source is raised together with every lower level source; the pulse sources stay low
        for (int i = 0; i < 7; i++) begin
            irq_src = uart_regs_pkg::irq_src_t'(
                ((10'h1 << (pos[i] + 1)) - 10'h1) & 10'h3f1);
            rdchk(4'h2, 8'h00, {2'b00, code[i]}, "code");
            chk("pend", 8'h01, 8'(irq_pending));
        end
        irq_src = '0;
    endtask

    task automatic t_flags();
        // let the edge pass so the sources are not driven twice at once
        @(negedge ref_clk);
        irq_src.xoff_seen = 1'b1;
        @(negedge ref_clk);
        irq_src.xoff_seen = 1'b0;
        rdchk(4'h2, 8'h00, 8'h10, "pause");
        rdchk(4'h2, 8'h00, 8'h10, "pause");
        irq_src.xon_seen = 1'b1;
        @(negedge ref_clk);
        irq_src.xon_seen = 1'b0;
        rdchk(4'h2, 8'h00, 8'h01, "resume");
        irq_src.special_seen = 1'b1;
        @(negedge ref_clk);
        irq_src.special_seen = 1'b0;
        rdchk(4'h2, 8'h00, 8'h10, "special");
        rdchk(4'h2, 8'h00, 8'h01, "special");
        @(negedge ref_clk);
        chk("pend", 8'h00, 8'(irq_pending));
    endtask

    task automatic give_verdict();
        if (num_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial begin
        #20us;
        num_errors++;
        give_verdict();
    end

    initial begin
        rst_n = 1'b0;
        sw_reset = 1'b0;
        enh_enable = 1'b0;
        irq_src = '0;
        repeat (6) @(negedge ref_clk);
        rst_n = 1'b1;
        t_reset();
        t_divisor();
        t_fifo();
        t_prio();
        t_flags();
        give_verdict();
    end
endmodule
`default_nettype wire
